//--- core/mcdm_deadtime.sv
// Deadtime generator producing a complementary pair from one phase
`timescale 1ns/10ps
`include "mcdm_map.svh"
module mcdm_deadtime (
   // Clock and control
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       ce_i,
   // Setup and phase
   input  wire logic [5:0] dtg_i,
   input  wire logic       phase_i,
   // Complementary outputs
   output logic            a_o,
   output logic            b_o
);
   import mcdm_pkg::*;

   function automatic mcdm_dly_t dt_cycles(input logic [5:0] d);
      if (!d[5])
         return ({4'h0, d[4:0]} + 9'h001) * `MCDM_DT_STEP_FINE;
      else if (!d[4])
         return ({5'h00, d[3:0]} + `MCDM_DT_BASE_WIDE) * `MCDM_DT_STEP_MID;
      else
         return ({5'h00, d[3:0]} + `MCDM_DT_BASE_WIDE) *
                `MCDM_DT_STEP_COARSE;
   endfunction

   mcdm_dly_t dly;
   mcdm_dly_t cnt;
   logic      prev;
   logic      reached;

   assign dly     = dt_cycles(dtg_i);                          // [R17]
   // A pulse shorter than the delay restarts the count and never shows
   assign reached = (cnt >= dly) && (phase_i == prev);         // [R16]
   assign a_o     = phase_i & reached;                         // [R14]
   assign b_o     = ~phase_i & reached;                        // [R15]

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         prev <= 1'b0;
         cnt  <= 9'h000;
      end
      else if (ce_i)
      begin
         prev <= phase_i;
         if (phase_i != prev)
            cnt <= 9'h001;
         else if (cnt < dly)
            cnt <= cnt + 9'h001;
      end
   end

   default clocking dcb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   a_edge_delay: assert property (                              // [R14]
      ($rose(phase_i) && ce_i) |-> !a_o ##1 !a_o)
      else $error("A output rose with the phase edge");
   a_b_edge_delay: assert property (                            // [R15]
      ($fell(phase_i) && ce_i) |-> !b_o ##1 !b_o)
      else $error("B output rose with the phase falling edge");
endmodule

//--- core/mcdm_map.svh
// Register offsets, field positions, reset values and timing steps
`ifndef MCDM_MAP_SVH
`define MCDM_MAP_SVH

// Byte offsets on the register bus
`define MCDM_OFS_PHASE_PRE  8'h00
`define MCDM_OFS_POLARITY   8'h04
`define MCDM_OFS_GROUP      8'h08
`define MCDM_OFS_CTRL_A     8'h0c
`define MCDM_OFS_CTRL_B     8'h10
`define MCDM_OFS_IRQ_MASK   8'h14
`define MCDM_OFS_STATUS     8'h18
`define MCDM_OFS_DEADTIME   8'h1c
`define MCDM_OFS_PHASE_ACT  8'h20

// Field positions
`define MCDM_CTRL_A_MOE     0
`define MCDM_CTRL_A_DAC     1
`define MCDM_CTRL_B_OS0     0
`define MCDM_CTRL_B_OS1     1
`define MCDM_CTRL_B_OS2     2
`define MCDM_MASK_EIM       0
`define MCDM_STAT_ESTOP     0
`define MCDM_STAT_PIN       1
`define MCDM_DT_DTE         6
`define MCDM_DT_PCN         7

// Reset values
`define MCDM_CHAN_RESET     6'h00
`define MCDM_DT_RESET       8'hff

// Reset state option codes of the output pins
`define MCDM_RST_HIZ        2'h0
`define MCDM_RST_LOW        2'h1
`define MCDM_RST_HIGH       2'h2

// Deadtime step in deadtime clock periods
`define MCDM_DT_STEP_FINE   9'h002
`define MCDM_DT_STEP_MID    9'h004
`define MCDM_DT_STEP_COARSE 9'h008
// Wide ranges continue where the range below ends, at seventeen steps
`define MCDM_DT_BASE_WIDE   9'h011

`endif

//--- core/mcdm_pkg.sv
// Types shared by the channel manager modules
package mcdm_pkg;
   typedef logic [5:0] mcdm_chan_t;
   typedef logic [8:0] mcdm_dly_t;
   typedef enum logic [1:0] {
      MCDM_WIN_DEMAG,
      MCDM_WIN_BEMF,
      MCDM_WIN_ZERO
   } mcdm_win_e;
endpackage

//--- core/mcdm_sync.sv
// Three-stage synchroniser that accepts a level once two stages agree
`timescale 1ns/10ps
module mcdm_sync #(
   parameter bit RESET_VAL = 1'b1
) (
   // Clock and control
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic ce_i,
   // Level
   input  wire logic d_i,
   output logic      q_o
);
   logic s1;
   logic s2;
   logic s3;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s1  <= RESET_VAL;
         s2  <= RESET_VAL;
         s3  <= RESET_VAL;
         q_o <= RESET_VAL;
      end
      else if (ce_i)
      begin
         s1 <= d_i;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3)
            q_o <= s3;
      end
   end
endmodule

//--- core/mcdm_top.sv
// Motor channel manager with phase register, steering and deadtime
// Overview of operation
// R1: Preload copied into phase on commutation.
// R2: Off idles at inverse polarity, on at polarity.
// R3: Direct access write triggers commutation immediately.
// R4: Direct access uses lowest apply bit only.
// R5: Master enable off forces reset state.
// R6: Reset state option: float, low or high.
// R7: Group bit 0 high, 1 low.
// R8: Demag window uses preloaded top apply bit.
// R9: Middle apply bit between demag end, zero.
// R10: Lowest apply bit from zero to commutation.
// R11: Emergency low forces reset state asynchronously.
// R12: Emergency clears master enable, may raise interrupt.
// R13: Emergency path works without clock.
// R14: First deadtime output delays rising edge.
// R15: Second output inverted, rising edge delayed.
// R16: Pulses shorter than delay are suppressed.
// R17: Deadtime step and count from code.
// R18: One code shared, undivided deadtime clock.
// R19: Deadtime code accepts only first write.
// R20: Deadtime enable read-only while three-PWM set.
// R21: Three-PWM without deadtime gives plain complements.
// R22: Deadtime register resets to all ones.
// R23: Software writes code before clearing three-PWM.
//
// The placing of the registers and the Wishbone register port are this design's own decisions.
`timescale 1ns/10ps
`include "mcdm_map.svh"
module mcdm_top (
   // Clock, reset and enable
   input  wire logic                clk_i,
   input  wire logic                rst_i,
   input  wire logic                ce_i,
   // Wishbone slave
   input  wire logic                cyc_i,
   input  wire logic                stb_i,
   input  wire logic                we_i,
   input  wire logic [7:0]          adr_i,
   input  wire logic [3:0]          sel_i,
   input  wire logic [31:0]         dat_i,
   output logic      [31:0]         dat_o,
   output logic                     ack_o,
   // Motor events, one-cycle pulses
   input  wire logic                comm_event_i,
   input  wire logic                demag_end_event_i,
   input  wire logic                zero_cross_event_i,
   // PWM phases
   input  wire logic                pwm_u_i,
   input  wire logic                pwm_v_i,
   input  wire logic                pwm_w_i,
   // Safety
   input  wire logic                emergency_stop_n_i,
   input  wire logic [1:0]          reset_state_opt_i,
   output logic                     emergency_irq_o,
   // Power stage
   output mcdm_pkg::mcdm_chan_t     motor_drive_outputs_o,
   output mcdm_pkg::mcdm_chan_t     motor_drive_oe_o
);
   import mcdm_pkg::*;

   function automatic logic hit(input logic [7:0] adr,
                                input logic [7:0] ofs);
      return adr == ofs;
   endfunction

   mcdm_chan_t  phase_state_preload_reg;
   mcdm_chan_t  polarity_register;
   mcdm_chan_t  group_assignment_reg;
   mcdm_chan_t  phase;
   mcdm_chan_t  drv_q;
   mcdm_chan_t  oe_q;
   mcdm_chan_t  next_drv;
   mcdm_chan_t  next_oe;
   logic        master_output_enable;
   logic        direct_access;
   logic [2:0]  pwm_apply;
   logic        pwm_apply_demag_phase;
   logic        emergency_irq_mask;
   logic        estop_flag;
   logic [5:0]  dtg;
   logic        deadtime_enable;
   logic        three_pwm_select;
   logic        dtg_locked;
   mcdm_win_e   win;
   logic        stop_lvl;
   logic        stop_prev;
   logic        stop_fall;
   logic        wb_req;
   logic        wr;
   logic        dac_write;
   logic        comm;
   logic        pwm_sel;
   logic        rst_level;
   logic        rst_oe;
   logic [2:0]  pwm_in;
   logic [2:0]  dt_a;
   logic [2:0]  dt_b;
   logic [31:0] next_rdata;

   assign wb_req    = cyc_i & stb_i & ~ack_o;
   assign wr        = wb_req & we_i & sel_i[0];
   assign dac_write = wr & hit(adr_i, `MCDM_OFS_PHASE_PRE) & direct_access;
   assign comm      = comm_event_i | dac_write;                 // [R3]
   assign pwm_in    = {pwm_w_i, pwm_v_i, pwm_u_i};
   assign rst_level = (reset_state_opt_i == `MCDM_RST_HIGH);    // [R6]
   assign rst_oe    = (reset_state_opt_i != `MCDM_RST_HIZ);     // [R6]
   assign stop_fall = stop_prev & ~stop_lvl;

   // Register bus answer: one wait state, unmapped reads give zero
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ack_o <= 1'b0;
      else if (ce_i)
         ack_o <= cyc_i & stb_i & ~ack_o;
   end

   always_comb
   begin
      next_rdata = 32'h0000_0000;
      if (hit(adr_i, `MCDM_OFS_PHASE_PRE))
         next_rdata[5:0] = phase_state_preload_reg;
      else if (hit(adr_i, `MCDM_OFS_POLARITY))
         next_rdata[5:0] = polarity_register;
      else if (hit(adr_i, `MCDM_OFS_GROUP))
         next_rdata[5:0] = group_assignment_reg;
      else if (hit(adr_i, `MCDM_OFS_CTRL_A))
         next_rdata[1:0] = {direct_access, master_output_enable};
      else if (hit(adr_i, `MCDM_OFS_CTRL_B))
         next_rdata[2:0] = pwm_apply;
      else if (hit(adr_i, `MCDM_OFS_IRQ_MASK))
         next_rdata[0] = emergency_irq_mask;
      else if (hit(adr_i, `MCDM_OFS_STATUS))
         next_rdata[3:0] = {2'(win), stop_lvl, estop_flag};
      else if (hit(adr_i, `MCDM_OFS_DEADTIME))
         next_rdata[7:0] = {three_pwm_select, deadtime_enable, dtg};
      else if (hit(adr_i, `MCDM_OFS_PHASE_ACT))
         next_rdata[5:0] = phase;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         dat_o <= 32'h0000_0000;
      else if (ce_i && wb_req)
         dat_o <= next_rdata;
   end

   // Plain channel configuration registers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         phase_state_preload_reg <= `MCDM_CHAN_RESET;
         polarity_register       <= `MCDM_CHAN_RESET;
         group_assignment_reg    <= `MCDM_CHAN_RESET;
         direct_access           <= 1'b0;
         pwm_apply               <= 3'h0;
         emergency_irq_mask      <= 1'b0;
      end
      else if (ce_i && wr)
      begin
         if (hit(adr_i, `MCDM_OFS_PHASE_PRE))
            phase_state_preload_reg <= dat_i[5:0];              // [R1]
         else if (hit(adr_i, `MCDM_OFS_POLARITY))
            polarity_register <= dat_i[5:0];
         else if (hit(adr_i, `MCDM_OFS_GROUP))
            group_assignment_reg <= dat_i[5:0];
         else if (hit(adr_i, `MCDM_OFS_CTRL_A))
            direct_access <= dat_i[`MCDM_CTRL_A_DAC];
         else if (hit(adr_i, `MCDM_OFS_CTRL_B))
            pwm_apply <= dat_i[2:0];
         else if (hit(adr_i, `MCDM_OFS_IRQ_MASK))
            emergency_irq_mask <= dat_i[`MCDM_MASK_EIM];
      end
   end

   // Active phase register; a direct write wins over a coincident event
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         phase                 <= `MCDM_CHAN_RESET;
         pwm_apply_demag_phase <= 1'b0;
      end
      else if (ce_i && comm)
      begin
         phase <= dac_write ? dat_i[5:0]                        // [R3]
                            : phase_state_preload_reg;          // [R1]
         pwm_apply_demag_phase <= pwm_apply[`MCDM_CTRL_B_OS2];  // [R8]
      end
   end

   // Commutation window tracking
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         win <= MCDM_WIN_ZERO;
      else if (ce_i)
      begin
         case (win)
            MCDM_WIN_DEMAG:
               if (comm)
                  win <= MCDM_WIN_DEMAG;
               else if (demag_end_event_i)
                  win <= MCDM_WIN_BEMF;
            MCDM_WIN_BEMF:
               if (comm)
                  win <= MCDM_WIN_DEMAG;
               else if (zero_cross_event_i)
                  win <= MCDM_WIN_ZERO;
            default:
               if (comm)
                  win <= MCDM_WIN_DEMAG;
         endcase
      end
   end

   always_comb
   begin
      pwm_sel = pwm_apply[`MCDM_CTRL_B_OS0];
      if (direct_access)
         pwm_sel = pwm_apply[`MCDM_CTRL_B_OS0];                 // [R4]
      else
      begin
         case (win)
            MCDM_WIN_DEMAG:
               pwm_sel = pwm_apply_demag_phase;                 // [R8]
            MCDM_WIN_BEMF:
               pwm_sel = pwm_apply[`MCDM_CTRL_B_OS1];           // [R9]
            default:
               pwm_sel = pwm_apply[`MCDM_CTRL_B_OS0];           // [R10]
         endcase
      end
   end

   // Emergency input, clocked view for register side effects
   mcdm_sync #(
      .RESET_VAL (1'b1)
   ) u_stop_sync (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .ce_i      (ce_i),
      .d_i       (emergency_stop_n_i),
      .q_o       (stop_lvl)
   );

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         stop_prev <= 1'b1;
      else if (ce_i)
         stop_prev <= stop_lvl;
   end

   // Enable stays cleared for as long as the stop input is held low
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         master_output_enable <= 1'b0;
      else if (ce_i)
      begin
         if (!stop_lvl)
            master_output_enable <= 1'b0;                       // [R12]
         else if (wr && hit(adr_i, `MCDM_OFS_CTRL_A))
            master_output_enable <= dat_i[`MCDM_CTRL_A_MOE];
      end
   end

   // Sticky stop flag, write one to clear; a new stop wins the clear
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         estop_flag <= 1'b0;
      else if (ce_i)
      begin
         if (stop_fall)
            estop_flag <= 1'b1;                                 // [R12]
         else if (wr && hit(adr_i, `MCDM_OFS_STATUS) &&
                  dat_i[`MCDM_STAT_ESTOP])
            estop_flag <= 1'b0;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         emergency_irq_o <= 1'b0;
      else if (ce_i)
         emergency_irq_o <= estop_flag & emergency_irq_mask;    // [R12]
   end

   // Deadtime setup: the code locks on the first write after reset
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         dtg              <= 6'(`MCDM_DT_RESET);
         deadtime_enable  <= 1'b1;                              // [R22]
         three_pwm_select <= 1'b1;                              // [R22]
         dtg_locked       <= 1'b0;
      end
      else if (ce_i && wr && hit(adr_i, `MCDM_OFS_DEADTIME))
      begin
         if (!dtg_locked)
         begin
            dtg        <= dat_i[5:0];                           // [R19]
            dtg_locked <= 1'b1;
         end
         three_pwm_select <= dat_i[`MCDM_DT_PCN];
         if (!three_pwm_select)
            deadtime_enable <= dat_i[`MCDM_DT_DTE];             // [R20]
      end
   end

   // One shared code, timed straight from the undivided clock
   for (genvar k = 0; k < 3; k++)
   begin : g_dt
      mcdm_deadtime u_dt (
         .clk_i   (clk_i),
         .rst_i   (rst_i),
         .ce_i    (ce_i),
         .dtg_i   (dtg),                                        // [R18]
         .phase_i (pwm_in[k]),
         .a_o     (dt_a[k]),
         .b_o     (dt_b[k])
      );
   end

   // Output level per channel before the emergency gate
   always_comb
   begin
      logic act;
      logic src;
      act      = 1'b0;
      src      = 1'b0;
      next_drv = `MCDM_CHAN_RESET;
      next_oe  = `MCDM_CHAN_RESET;
      for (int x = 0; x < 6; x++)
      begin
         if (three_pwm_select)
         begin
            if (deadtime_enable)
               src = x[0] ? dt_b[x/2] : dt_a[x/2];              // [R14]
            else
               src = x[0] ? ~pwm_in[x/2] : pwm_in[x/2];         // [R21]
         end
         else if (group_assignment_reg[x] == pwm_sel)
            src = pwm_u_i;                                      // [R7]
         else
            src = 1'b1;
         act = phase[x] & src;
         if (master_output_enable)
         begin
            next_drv[x] = act ? polarity_register[x]            // [R2]
                              : ~polarity_register[x];
            next_oe[x]  = 1'b1;                                 // [R5]
         end
         else
         begin
            next_drv[x] = rst_level;                            // [R5]
            next_oe[x]  = rst_oe;
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         drv_q <= `MCDM_CHAN_RESET;
         oe_q  <= `MCDM_CHAN_RESET;
      end
      else if (ce_i)
      begin
         drv_q <= next_drv;
         oe_q  <= next_oe;
      end
   end

   // Gate needs no clock so a stop works with the oscillator halted
   assign motor_drive_outputs_o = emergency_stop_n_i ? drv_q   // [R11]
                                  : {6{rst_level}};            // [R13]
   assign motor_drive_oe_o      = emergency_stop_n_i ? oe_q    // [R11]
                                  : {6{rst_oe}};               // [R13]

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_stop_held;
      $fell(emergency_stop_n_i) ##1 (!emergency_stop_n_i && ce_i) [*6];
   endsequence

   a_comm_loads: assert property (                              // [R1]
      (comm_event_i && !dac_write && ce_i) |=>
         phase == $past(phase_state_preload_reg))
      else $error("Commutation did not load the preload");
   a_dac_write: assert property (                               // [R3]
      (dac_write && ce_i) |=> phase == $past(dat_i[5:0]))
      else $error("Direct write did not reach phase");
   a_moe_reset: assert property (                               // [R5]
      (!master_output_enable && ce_i) |=>
         oe_q == {6{$past(rst_oe)}})
      else $error("Outputs left reset state with enable low");
   a_stop_async: assert property (                              // [R11]
      !emergency_stop_n_i |-> motor_drive_oe_o == {6{rst_oe}} &&
         motor_drive_outputs_o == {6{rst_level}})
      else $error("Stop did not force reset state");
   a_stop_clears: assert property (                             // [R12]
      s_stop_held |-> !master_output_enable && estop_flag)
      else $error("Stop left enable set or flag clear");
   a_code_once: assert property (                               // [R19]
      (dtg_locked && ce_i) |=> $stable(dtg))
      else $error("Deadtime code changed after lock");
   a_dte_locked: assert property (                              // [R20]
      (three_pwm_select && ce_i) |=> $stable(deadtime_enable))
      else $error("Deadtime enable changed while three-PWM set");
   a_demag_sel: assert property (                               // [R8]
      (win == MCDM_WIN_DEMAG && !direct_access) |->
         pwm_sel == pwm_apply_demag_phase)
      else $error("Demag window ignored preloaded bit");
endmodule

//--- testbench/mcdm_gate_model.sv
// Gate driver model of the power stage: resolves pins, flags shoot-through
`timescale 1ns/10ps
module mcdm_gate_model (
   // From the channel manager
   input  wire logic [5:0] drv_i,
   input  wire logic [5:0] oe_i,
   // Resolved gate levels
   output logic      [5:0] pin_o,
   output logic            shoot_o
);
   // Pull-downs keep a floating gate off, so Hi-Z reads as 0
   assign pin_o   = drv_i & oe_i;
   assign shoot_o = (pin_o[0] & pin_o[1]) | (pin_o[2] & pin_o[3])
                  | (pin_o[4] & pin_o[5]);
endmodule

//--- testbench/testbench.sv
// Self-checking bench for the motor channel manager
`timescale 1ns/10ps
`include "mcdm_map.svh"
module testbench;
   import mcdm_pkg::*;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc_i = 1'b0;
   logic        stb_i = 1'b0;
   logic        we_i = 1'b0;
   logic [7:0]  adr_i = 8'h00;
   logic [31:0] dat_i = 32'h0;
   logic        comm = 1'b0;
   logic        dmag = 1'b0;
   logic        zero = 1'b0;
   logic        pwm_u = 1'b0;
   logic        pwm_v = 1'b0;
   logic        pwm_w = 1'b0;
   logic        stop_n = 1'b1;
   logic [1:0]  opt = 2'h1;
   logic [31:0] dat_o;
   logic        ack_o;
   logic        irq;
   mcdm_chan_t  drv;
   mcdm_chan_t  oe;
   logic [5:0]  pin;
   logic        shoot;
   logic [5:0]  p;
   logic [5:0]  q;
   logic        seen;
   logic [31:0] rd_q[$];
   logic [11:0] pin_q[$];
   int          fail_count = 0;
   int          comparisons = 0;
   int          seed = 93;
   event        pin_ev;

   mcdm_top u_mcdm_top (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
      .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
      .sel_i(4'hf), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .comm_event_i(comm), .demag_end_event_i(dmag),
      .zero_cross_event_i(zero), .pwm_u_i(pwm_u), .pwm_v_i(pwm_v),
      .pwm_w_i(pwm_w), .emergency_stop_n_i(stop_n),
      .reset_state_opt_i(opt), .emergency_irq_o(irq),
      .motor_drive_outputs_o(drv), .motor_drive_oe_o(oe)
   );
   mcdm_gate_model u_mcdm_gate_model (
      .drv_i(drv), .oe_i(oe), .pin_o(pin), .shoot_o(shoot)
   );

   always #20 clk_i = ~clk_i;
   // Unused phases still toggle so stray steering would show on the pins
   always @(posedge clk_i)
   begin
      pwm_v <= 1'($random(seed));
      pwm_w <= 1'($random(seed));
   end

   task automatic cmp_reg(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e)
      begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic cmp_pin(input logic [11:0] g, input logic [11:0] e);
      comparisons++;
      if (g !== e)
      begin
         fail_count++;
         $display("[FAIL] t=%0t pins got=%h exp=%h", $time, g, e);
      end
   endtask

   always @(posedge clk_i)
      if (ack_o === 1'b1 && we_i === 1'b0 && rd_q.size() > 0)
         cmp_reg(dat_o, rd_q.pop_front());
   always @(pin_ev)
      cmp_pin({pin, oe}, pin_q.pop_front());

   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      dat_i <= d;
      do
         @(posedge clk_i);
      while (ack_o !== 1'b1 && ++n < 64);
      if (n >= 64)
      begin
         fail_count++;
         print_verdict();
      end
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      rd_q.push_back(e);
      wb(1'b0, a, 32'h0);
   endtask
   task automatic pchk(input logic [5:0] e, input logic [5:0] eo);
      pin_q.push_back({e, eo});
      #1;
      -> pin_ev;
      // Realign so the next stimulus is driven at a rising edge
      @(posedge clk_i);
   endtask
   task automatic pw(input logic v, input int n, input logic [5:0] e);
      @(posedge clk_i);
      pwm_u <= v;
      repeat (n) @(posedge clk_i);
      pchk(e, 6'h3f);
   endtask
   // Event kind 0 commutation, 1 demag end, 2 zero crossing
   task automatic pulse(input int k, input logic [5:0] e);
      @(posedge clk_i);
      comm <= (k == 0);
      dmag <= (k == 1);
      zero <= (k == 2);
      @(posedge clk_i);
      comm <= 1'b0;
      dmag <= 1'b0;
      zero <= 1'b0;
      repeat (3) @(posedge clk_i);
      pchk(e, 6'h3f);
   endtask

   task automatic print_verdict();
      $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   initial
   begin
      #(40 * 20000);
      fail_count++;
      print_verdict();
   end

   initial
   begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(`MCDM_OFS_DEADTIME, 32'hff);
      rd(8'h3c, 32'h0);
      wr(`MCDM_OFS_DEADTIME, 32'h85);
      rd(`MCDM_OFS_DEADTIME, 32'hc5);
      wr(`MCDM_OFS_DEADTIME, 32'h8a);
      rd(`MCDM_OFS_DEADTIME, 32'hc5);
      repeat (2) wr(`MCDM_OFS_DEADTIME, 32'h05);
      rd(`MCDM_OFS_DEADTIME, 32'h05);
      wr(`MCDM_OFS_PHASE_PRE, 32'h2d);
      rd(`MCDM_OFS_PHASE_ACT, 32'h0);
      pulse(0, 6'h00);
      rd(`MCDM_OFS_PHASE_ACT, 32'h2d);
      for (int o = 0; o < 3; o++)
      begin
         opt <= 2'(o);
         repeat (3) @(posedge clk_i);
         pchk((o == 2) ? 6'h3f : 6'h0, (o != 0) ? 6'h3f : 6'h0);
      end
      opt <= 2'h1;
      wr(`MCDM_OFS_GROUP, 32'h3f);
      wr(`MCDM_OFS_CTRL_B, 32'h0);
      wr(`MCDM_OFS_CTRL_A, 32'h3);
      for (int i = 0; i < 8; i++)
      begin
         p = 6'($random(seed));
         q = 6'($random(seed));
         wr(`MCDM_OFS_POLARITY, {26'h0, p});
         wr(`MCDM_OFS_PHASE_PRE, {26'h0, q});
         repeat (3) @(posedge clk_i);
         pchk(~(p ^ q), 6'h3f);
      end
      wr(`MCDM_OFS_POLARITY, 32'h3f);
      wr(`MCDM_OFS_PHASE_PRE, 32'h3f);
      wr(`MCDM_OFS_CTRL_B, 32'h1);
      pw(1'b1, 4, 6'h3f);
      pw(1'b0, 4, 6'h00);
      wr(`MCDM_OFS_CTRL_B, 32'h6);
      // Latch a set top bit so the demag choice differs from the lowest
      wr(`MCDM_OFS_PHASE_PRE, 32'h3f);
      pw(1'b0, 4, 6'h3f);
      wr(`MCDM_OFS_CTRL_A, 32'h1);
      wr(`MCDM_OFS_CTRL_B, 32'h4);
      pulse(0, 6'h00);
      pulse(1, 6'h3f);
      pulse(2, 6'h3f);
      wr(`MCDM_OFS_CTRL_B, 32'h3);
      pulse(0, 6'h3f);
      // Top apply bit changes without a commutation: demag keeps old one
      wr(`MCDM_OFS_CTRL_B, 32'h7);
      repeat (3) @(posedge clk_i);
      pchk(6'h3f, 6'h3f);
      pulse(1, 6'h00);
      pulse(2, 6'h00);
      wr(`MCDM_OFS_IRQ_MASK, 32'h1);
      pw(1'b1, 3, 6'h3f);
      stop_n <= 1'b0;
      pchk(6'h00, 6'h3f);
      repeat (8) @(posedge clk_i);
      cmp_reg({31'h0, irq}, 32'h1);
      rd(`MCDM_OFS_CTRL_A, 32'h0);
      stop_n <= 1'b1;
      repeat (6) @(posedge clk_i);
      wr(`MCDM_OFS_STATUS, 32'h1);
      repeat (3) @(posedge clk_i);
      cmp_reg({31'h0, irq}, 32'h0);
      wr(`MCDM_OFS_DEADTIME, 32'h85);
      rd(`MCDM_OFS_DEADTIME, 32'h85);
      wr(`MCDM_OFS_CTRL_A, 32'h3);
      wr(`MCDM_OFS_PHASE_PRE, 32'h03);
      pw(1'b1, 4, 6'h01);
      pw(1'b0, 4, 6'h02);
      repeat (2) wr(`MCDM_OFS_DEADTIME, 32'h45);
      wr(`MCDM_OFS_DEADTIME, 32'hc5);
      rd(`MCDM_OFS_DEADTIME, 32'hc5);
      pw(1'b0, 20, 6'h02);
      pw(1'b1, 12, 6'h00);
      pw(1'b1, 12, 6'h01);
      // A low pulse shorter than the 12-cycle delay must not reach B
      seen = 1'b0;
      pwm_u <= 1'b0;
      repeat (4) @(posedge clk_i);
      pwm_u <= 1'b1;
      repeat (24)
      begin
         @(posedge clk_i);
         seen = seen | pin[1] | shoot;
      end
      cmp_reg({31'h0, seen}, 32'h0);
      pchk(6'h01, 6'h3f);
      print_verdict();
   end
endmodule
